/* File: include/uart_shadow_cfg.svh */
// Offsets, field positions, reset values and timing counts of the shadow receive and transmit path
`ifndef UART_SHADOW_CFG_SVH
`define UART_SHADOW_CFG_SVH

`define UART_SLOT_BASE      32'h50001030
`define UART_SLOT_SPAN      32'h00000040
`define UART_SLOT_13_ADDR   32'h50001064
`define UART_SLOT_14_ADDR   32'h50001068
`define UART_CTRL_ADDR      32'h50001070
`define UART_LSTAT_ADDR     32'h50001074
`define UART_ISTAT_ADDR     32'h50001078
`define UART_IMASK_ADDR     32'h5000107c

`define UART_CTRL_FIFO_BIT  0
`define UART_CTRL_IR_BIT    1
`define UART_LSR_DR_BIT     0
`define UART_LSR_OE_BIT     1
`define UART_LSR_TX_HOLDING_EMPTY_FLAG_BIT   5
`define UART_IRQ_RX_BIT     0
`define UART_IRQ_OE_BIT     1
`define UART_IRQ_TX_HOLDING_EMPTY_FLAG_BIT   2
`define UART_IRQ_DROP_BIT   3

`define UART_SLOT_RESET     8'h00
`define UART_FIFO_DEPTH     5'h10
`define UART_CLK_HZ         100000000
`define UART_BAUD_HZ        115200
`define UART_BIT_CYCLES     ((`UART_CLK_HZ) / (`UART_BAUD_HZ))
`define UART_HALF_CYCLES    ((`UART_BIT_CYCLES) / 2)

`endif

/* File: include/uart_shadow_pkg.sv */
// Types shared by the shadow receive and transmit path
package uart_shadow_pkg;

  typedef enum logic [1:0] {
    SER_IDLE  = 2'b00,
    SER_START = 2'b01,
    SER_DATA  = 2'b11,
    SER_STOP  = 2'b10
  } ser_state_t;

  typedef struct packed {
    ser_state_t  rx_st;
    logic [11:0] rx_cnt;
    logic [2:0]  rx_bit;
    logic [7:0]  rx_shift;
    logic [7:0]  rx_hold;
    logic        rx_hold_full;
    logic [3:0]  rx_head;
    logic [3:0]  rx_tail;
    logic [4:0]  rx_count;
    ser_state_t  tx_st;
    logic [11:0] tx_cnt;
    logic [2:0]  tx_bit;
    logic [7:0]  tx_shift;
    logic        tx_line;
    logic [7:0]  tx_hold;
    logic        tx_hold_full;
    logic [3:0]  tx_head;
    logic [3:0]  tx_tail;
    logic [4:0]  tx_count;
    logic        tx_fetch;
    logic        rd_from_mem;
    logic [31:0] rd_data;
    logic        fifo_en;
    logic        ir_mode;
    logic        overrun;
    logic [3:0]  irq_status;
    logic [3:0]  irq_mask;
  } state_t;

endpackage

/* File: rtl/uart_shadow_sync.sv */
// Two-stage synchronisers for the serial input pins
`timescale 1ns/1ns
module uart_shadow_sync (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Asynchronous pins and their synchronised copies
  input  wire logic [1:0] pins_in,
  output logic      [1:0] pins_out
);

  logic [1:0] meta_reg;
  logic [1:0] sync_reg;

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_bit
      // Idle line is high, so reset to high
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          meta_reg[i] <= 1'b1;
          sync_reg[i] <= 1'b1;
        end else begin
          meta_reg[i] <= pins_in[i];
          sync_reg[i] <= meta_reg[i];
        end
      end
    end
  endgenerate

  assign pins_out = sync_reg;

endmodule

/* File: rtl/uart_shadow_mem.sv */
// Sixteen-entry byte memory with registered read data
`timescale 1ns/1ns
module uart_shadow_mem (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Write port
  input  wire logic       wr_en_in,
  input  wire logic [3:0] wr_addr_in,
  input  wire logic [7:0] wr_data_in,
  // Read port, data one cycle after the enable
  input  wire logic       rd_en_in,
  input  wire logic [3:0] rd_addr_in,
  output logic      [7:0] rd_data_out
);

  logic [7:0] mem_reg [0:15];
  logic [7:0] rd_reg;

  // Array left without reset so it maps to plain storage
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_reg[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_reg <= 8'h00;
    end else if (rd_en_in) begin
      rd_reg <= mem_reg[rd_addr_in];
    end
  end

  assign rd_data_out = rd_reg;

endmodule

/* File: rtl/uart_shadow_rx_tx_buffer.sv */
// Shadow receive buffer and transmit holding path with optional FIFOs and a simple serial shifter
//
// Contract
// - Sixteen word slots alias both byte paths
// - Slot read returns received byte
// - Serial or infrared pins chosen by mode
// - No FIFO: new byte overwrites, flags overrun
// - FIFO mode: read returns receive FIFO head
// - Full receive FIFO: keep contents, drop, overrun
// - No FIFO: one write clears holding empty
// - No FIFO: later write replaces held byte
// - FIFO mode: accept up to sixteen writes
// - Write to full transmit FIFO is lost
`timescale 1ns/1ns
`include "uart_shadow_cfg.svh"
module uart_shadow_rx_tx_buffer (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Register port
  input  wire logic [31:0] addr_in,
  input  wire logic [31:0] wr_data_in,
  input  wire logic        wr_en_in,
  input  wire logic        rd_en_in,
  output logic      [31:0] rd_data_out,
  // Serial pins
  input  wire logic        serial_in,
  input  wire logic        infrared_in,
  output logic             serial_out,
  output logic             infrared_out_low,
  // Status towards the rest of the UART
  output logic             rx_data_ready_out,
  output logic             tx_holding_empty_out,
  output logic             fifo_enable_out,
  output logic             overrun_out,
  output logic             irq_out
);

  localparam logic [11:0] BIT_CNT  = 12'(`UART_BIT_CYCLES - 1);
  localparam logic [11:0] HALF_CNT = 12'(`UART_HALF_CYCLES - 1);

  uart_shadow_pkg::state_t q_reg;
  uart_shadow_pkg::state_t q_next;

  logic [1:0]  pins_sync;
  logic [7:0]  rx_mem_q;
  logic [7:0]  tx_mem_q;
  logic        rx_mem_wr;
  logic        rx_mem_rd;
  logic        tx_mem_wr;
  logic        tx_mem_rd;
  logic [31:0] slot_off;
  logic        slot_hit;
  logic        rx_line;
  logic        dr_now;
  logic        tx_holding_empty_flag_now;

  uart_shadow_sync u_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .pins_in  ({infrared_in, serial_in}),
    .pins_out (pins_sync)
  );

  uart_shadow_mem u_rx_mem (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .wr_en_in    (rx_mem_wr),
    .wr_addr_in  (q_reg.rx_tail),
    .wr_data_in  (q_reg.rx_shift),
    .rd_en_in    (rx_mem_rd),
    .rd_addr_in  (q_reg.rx_head),
    .rd_data_out (rx_mem_q)
  );

  uart_shadow_mem u_tx_mem (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .wr_en_in    (tx_mem_wr),
    .wr_addr_in  (q_reg.tx_tail),
    .wr_data_in  (wr_data_in[7:0]),
    .rd_en_in    (tx_mem_rd),
    .rd_addr_in  (q_reg.tx_head),
    .rd_data_out (tx_mem_q)
  );

  assign slot_off = addr_in - `UART_SLOT_BASE;
  assign slot_hit = (slot_off < `UART_SLOT_SPAN) && (slot_off[1:0] == 2'h0);

  assign rx_line = q_reg.ir_mode ? pins_sync[1] : pins_sync[0];

  assign dr_now   = q_reg.fifo_en ? (q_reg.rx_count != 5'h00) : q_reg.rx_hold_full;
  assign tx_holding_empty_flag_now = q_reg.fifo_en ? (q_reg.tx_count == 5'h00) : !q_reg.tx_hold_full;

  always_comb begin
    logic       rx_done;
    logic       slot_rd;
    logic       slot_wr;
    logic       rx_pop;
    logic       rx_push;
    logic       tx_push;
    logic       tx_pop;
    logic [3:0] irq_set;
    logic [3:0] irq_clr;
    logic       oe_set;
    logic       oe_clr;
    rx_done = 1'b0;
    slot_rd = rd_en_in && slot_hit;
    slot_wr = wr_en_in && slot_hit;
    rx_pop  = 1'b0;
    rx_push = 1'b0;
    tx_push = 1'b0;
    tx_pop  = 1'b0;
    irq_set = 4'h0;
    irq_clr = 4'h0;
    oe_set  = 1'b0;
    oe_clr  = 1'b0;
    q_next  = q_reg;
    q_next.rd_from_mem = 1'b0;
    q_next.rd_data     = 32'h00000000;

    // Receive shifter, start bit checked at mid-bit
    case (q_reg.rx_st)
      uart_shadow_pkg::SER_IDLE: begin
        if (!rx_line) begin
          q_next.rx_st  = uart_shadow_pkg::SER_START;
          q_next.rx_cnt = HALF_CNT;
        end
      end
      uart_shadow_pkg::SER_START: begin
        if (q_reg.rx_cnt != 12'h000) begin
          q_next.rx_cnt = q_reg.rx_cnt - 12'h001;
        end else if (!rx_line) begin
          q_next.rx_st  = uart_shadow_pkg::SER_DATA;
          q_next.rx_cnt = BIT_CNT;
          q_next.rx_bit = 3'h0;
        end else begin
          q_next.rx_st = uart_shadow_pkg::SER_IDLE;
        end
      end
      uart_shadow_pkg::SER_DATA: begin
        if (q_reg.rx_cnt != 12'h000) begin
          q_next.rx_cnt = q_reg.rx_cnt - 12'h001;
        end else begin
          q_next.rx_shift = {rx_line, q_reg.rx_shift[7:1]};
          q_next.rx_cnt   = BIT_CNT;
          q_next.rx_bit   = q_reg.rx_bit + 3'h1;
          if (q_reg.rx_bit == 3'h7) begin
            q_next.rx_st = uart_shadow_pkg::SER_STOP;
          end
        end
      end
      default: begin
        if (q_reg.rx_cnt != 12'h000) begin
          q_next.rx_cnt = q_reg.rx_cnt - 12'h001;
        end else begin
          // A bad stop bit drops the byte; no framing fault is flagged
          rx_done      = rx_line;
          q_next.rx_st = uart_shadow_pkg::SER_IDLE;
        end
      end
    endcase

    if (slot_rd) begin
      if (q_reg.fifo_en) begin
        q_next.rd_from_mem = 1'b1;
        rx_pop = (q_reg.rx_count != 5'h00);
      end else begin
        q_next.rd_data       = {24'h000000, q_reg.rx_hold};
        q_next.rx_hold_full  = 1'b0;
      end
    end else if (rd_en_in) begin
      if (addr_in == `UART_CTRL_ADDR) begin
        q_next.rd_data[`UART_CTRL_FIFO_BIT] = q_reg.fifo_en;
        q_next.rd_data[`UART_CTRL_IR_BIT]   = q_reg.ir_mode;
      end else if (addr_in == `UART_LSTAT_ADDR) begin
        q_next.rd_data[`UART_LSR_DR_BIT]   = dr_now;
        q_next.rd_data[`UART_LSR_OE_BIT]   = q_reg.overrun;
        q_next.rd_data[`UART_LSR_TX_HOLDING_EMPTY_FLAG_BIT] = tx_holding_empty_flag_now;
        oe_clr = 1'b1;
      end else if (addr_in == `UART_ISTAT_ADDR) begin
        q_next.rd_data[3:0] = q_reg.irq_status;
      end else if (addr_in == `UART_IMASK_ADDR) begin
        q_next.rd_data[3:0] = q_reg.irq_mask;
      end
    end

    if (rx_done) begin
      if (q_reg.fifo_en) begin
        if ((q_reg.rx_count != `UART_FIFO_DEPTH) || rx_pop) begin
          rx_push = 1'b1;
          irq_set[`UART_IRQ_RX_BIT] = 1'b1;
        end else begin
          // Full FIFO keeps contents, new byte dropped
          oe_set = 1'b1;
        end
      end else begin
        if (q_reg.rx_hold_full && !slot_rd) begin
          oe_set = 1'b1;
        end
        q_next.rx_hold      = q_reg.rx_shift;
        q_next.rx_hold_full = 1'b1;
        irq_set[`UART_IRQ_RX_BIT] = 1'b1;
      end
    end

    if (rx_pop) begin
      q_next.rx_head = q_reg.rx_head + 4'h1;
    end
    if (rx_push) begin
      q_next.rx_tail = q_reg.rx_tail + 4'h1;
    end
    q_next.rx_count = q_reg.rx_count + {4'h0, rx_push} - {4'h0, rx_pop};

    // Transmit shifter, least significant bit first
    case (q_reg.tx_st)
      uart_shadow_pkg::SER_IDLE: begin
        q_next.tx_line = 1'b1;
        if (q_reg.tx_fetch) begin
          q_next.tx_shift = tx_mem_q;
          q_next.tx_line  = 1'b0;
          q_next.tx_cnt   = BIT_CNT;
          q_next.tx_st    = uart_shadow_pkg::SER_START;
          q_next.tx_fetch = 1'b0;
        end else if (q_reg.fifo_en && (q_reg.tx_count != 5'h00)) begin
          // Memory read takes a cycle, byte loads on the next
          tx_pop          = 1'b1;
          q_next.tx_fetch = 1'b1;
          if (q_reg.tx_count == 5'h01) begin
            irq_set[`UART_IRQ_TX_HOLDING_EMPTY_FLAG_BIT] = 1'b1;
          end
        end else if (!q_reg.fifo_en && q_reg.tx_hold_full) begin
          // Holding empty again once byte moves out
          q_next.tx_shift     = q_reg.tx_hold;
          q_next.tx_hold_full = 1'b0;
          q_next.tx_line      = 1'b0;
          q_next.tx_cnt       = BIT_CNT;
          q_next.tx_st        = uart_shadow_pkg::SER_START;
          irq_set[`UART_IRQ_TX_HOLDING_EMPTY_FLAG_BIT] = 1'b1;
        end
      end
      uart_shadow_pkg::SER_START: begin
        if (q_reg.tx_cnt != 12'h000) begin
          q_next.tx_cnt = q_reg.tx_cnt - 12'h001;
        end else begin
          q_next.tx_line = q_reg.tx_shift[0];
          q_next.tx_bit  = 3'h0;
          q_next.tx_cnt  = BIT_CNT;
          q_next.tx_st   = uart_shadow_pkg::SER_DATA;
        end
      end
      uart_shadow_pkg::SER_DATA: begin
        if (q_reg.tx_cnt != 12'h000) begin
          q_next.tx_cnt = q_reg.tx_cnt - 12'h001;
        end else begin
          q_next.tx_cnt = BIT_CNT;
          if (q_reg.tx_bit == 3'h7) begin
            q_next.tx_line = 1'b1;
            q_next.tx_st   = uart_shadow_pkg::SER_STOP;
          end else begin
            q_next.tx_shift = {1'b0, q_reg.tx_shift[7:1]};
            q_next.tx_line  = q_reg.tx_shift[1];
            q_next.tx_bit   = q_reg.tx_bit + 3'h1;
          end
        end
      end
      default: begin
        if (q_reg.tx_cnt != 12'h000) begin
          q_next.tx_cnt = q_reg.tx_cnt - 12'h001;
        end else begin
          q_next.tx_st = uart_shadow_pkg::SER_IDLE;
        end
      end
    endcase

    // Writes while busy are still handled as defined below
    if (slot_wr) begin
      if (q_reg.fifo_en) begin
        if ((q_reg.tx_count != `UART_FIFO_DEPTH) || tx_pop) begin
          tx_push = 1'b1;
        end else begin
          irq_set[`UART_IRQ_DROP_BIT] = 1'b1;
        end
      end else begin
        // Write fills or replaces held byte
        q_next.tx_hold      = wr_data_in[7:0];
        q_next.tx_hold_full = 1'b1;
        irq_set[`UART_IRQ_TX_HOLDING_EMPTY_FLAG_BIT] = 1'b0;
      end
    end

    if (tx_pop) begin
      q_next.tx_head = q_reg.tx_head + 4'h1;
    end
    if (tx_push) begin
      q_next.tx_tail = q_reg.tx_tail + 4'h1;
    end
    q_next.tx_count = q_reg.tx_count + {4'h0, tx_push} - {4'h0, tx_pop};

    if (wr_en_in && !slot_hit) begin
      if (addr_in == `UART_CTRL_ADDR) begin
        q_next.fifo_en = wr_data_in[`UART_CTRL_FIFO_BIT];
        q_next.ir_mode = wr_data_in[`UART_CTRL_IR_BIT];
        // Changing the FIFO enable flushes both paths; changing only the infrared mode does not
        if (wr_data_in[`UART_CTRL_FIFO_BIT] != q_reg.fifo_en) begin
          q_next.rx_head      = 4'h0;
          q_next.rx_tail      = 4'h0;
          q_next.rx_count     = 5'h00;
          q_next.rx_hold_full = 1'b0;
          q_next.tx_head      = 4'h0;
          q_next.tx_tail      = 4'h0;
          q_next.tx_count     = 5'h00;
          q_next.tx_hold_full = 1'b0;
          q_next.tx_fetch     = 1'b0;
        end
      end else if (addr_in == `UART_ISTAT_ADDR) begin
        irq_clr = wr_data_in[3:0];
      end else if (addr_in == `UART_IMASK_ADDR) begin
        q_next.irq_mask = wr_data_in[3:0];
      end
    end

    // Set wins over clear on sticky flags
    irq_set[`UART_IRQ_OE_BIT] = oe_set;
    q_next.irq_status = (q_reg.irq_status & ~irq_clr) | irq_set;
    q_next.overrun    = (q_reg.overrun & ~oe_clr) | oe_set;
  end

  assign rx_mem_wr = (q_next.rx_tail != q_reg.rx_tail);
  assign rx_mem_rd = rd_en_in && slot_hit && q_reg.fifo_en;
  assign tx_mem_wr = (q_next.tx_tail != q_reg.tx_tail);
  assign tx_mem_rd = (q_next.tx_head != q_reg.tx_head);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q_reg          <= '0;
      q_reg.rx_hold  <= `UART_SLOT_RESET;
      q_reg.tx_hold  <= `UART_SLOT_RESET;
      q_reg.tx_line  <= 1'b1;
    end else begin
      q_reg <= q_next;
    end
  end

  // Reserved bits 31:8 of a slot read as zero
  assign rd_data_out = q_reg.rd_from_mem ? {24'h000000, rx_mem_q} : q_reg.rd_data;

  // Transmit pin by mode, infrared output active low
  assign serial_out       = q_reg.ir_mode ? 1'b1 : q_reg.tx_line;
  assign infrared_out_low = q_reg.ir_mode ? q_reg.tx_line : 1'b1;

  assign rx_data_ready_out    = dr_now;
  assign tx_holding_empty_out = tx_holding_empty_flag_now;
  assign fifo_enable_out      = q_reg.fifo_en;
  assign overrun_out          = q_reg.overrun;
  assign irq_out              = |(q_reg.irq_status & q_reg.irq_mask);

endmodule

/* File: sim/uart_shadow_rx_tx_buffer_asserts.sv */
// Concurrent checks on the ports of the shadow receive and transmit path
`timescale 1ns/1ns
`include "uart_shadow_cfg.svh"
module uart_shadow_rx_tx_buffer_chk (
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        rst_in,
  // Register port
  input wire logic [31:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic        wr_en_in,
  input wire logic        rd_en_in,
  input wire logic [31:0] rd_data_out,
  // Serial pins
  input wire logic        serial_in,
  input wire logic        infrared_in,
  input wire logic        serial_out,
  input wire logic        infrared_out_low,
  // Status
  input wire logic        rx_data_ready_out,
  input wire logic        tx_holding_empty_out,
  input wire logic        fifo_enable_out,
  input wire logic        overrun_out,
  input wire logic        irq_out
);
  // A held byte waits at most eleven bit times for the shifter
  localparam int WAIT_MAX = 11 * `UART_BIT_CYCLES;
  logic        is_slot;
  logic        is_mapped;
  logic [15:0] wait_cnt;
  assign is_slot = addr_in >= `UART_SLOT_BASE && addr_in < `UART_SLOT_BASE + `UART_SLOT_SPAN
                   && addr_in[1:0] == 2'h0;
  assign is_mapped = is_slot || (addr_in >= `UART_CTRL_ADDR && addr_in <= `UART_IMASK_ADDR
                     && addr_in[1:0] == 2'h0);
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wait_cnt <= 16'h0;
    end else if (!fifo_enable_out && !tx_holding_empty_out) begin
      wait_cnt <= wait_cnt + 16'h1;
    end else begin
      wait_cnt <= 16'h0;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_slot_upper_zero: assert property (rd_en_in && is_slot |=> rd_data_out[31:8] == 24'h0)
    else $error("slot read shows bits above the byte");
  a_unmapped_zero: assert property (rd_en_in && !is_mapped |=> rd_data_out == 32'h0)
    else $error("unmapped read not zero");
  a_read_idle_zero: assert property (!rd_en_in |=> rd_data_out == 32'h0)
    else $error("read data outside its cycle");
  a_tx_holding_empty_flag_write_clears: assert property (
    wr_en_in && is_slot && !fifo_enable_out && tx_holding_empty_out |=> !tx_holding_empty_out)
    else $error("holding empty not cleared by write");
  a_fifo_flag_follows: assert property (
    wr_en_in && addr_in == `UART_CTRL_ADDR |=> fifo_enable_out == $past(wr_data_in[0]))
    else $error("fifo enable not taken from control");
  a_overrun_sticky: assert property (overrun_out && !rd_en_in && !wr_en_in |=> overrun_out)
    else $error("overrun lost without access");
  a_ready_kept: assert property (rx_data_ready_out && !rd_en_in && !wr_en_in |=> rx_data_ready_out)
    else $error("received data lost without read");
  a_tx_holding_empty_flag_returns: assert property (wait_cnt < WAIT_MAX)
    else $error("holding empty never set again");
  a_reset_idle: assert property (
    $fell(rst_in) |-> serial_out && infrared_out_low && tx_holding_empty_out && !rx_data_ready_out && !irq_out)
    else $error("outputs not idle after reset");
  a_overrun_keeps_data: assert property ($rose(overrun_out) && !$past(wr_en_in) |-> rx_data_ready_out)
    else $error("overrun lost the stored data");
endmodule
bind uart_shadow_rx_tx_buffer uart_shadow_rx_tx_buffer_chk uart_shadow_rx_tx_buffer_chk_i (
  .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in),
  .rd_en_in(rd_en_in), .rd_data_out(rd_data_out), .serial_in(serial_in), .infrared_in(infrared_in),
  .serial_out(serial_out), .infrared_out_low(infrared_out_low), .rx_data_ready_out(rx_data_ready_out),
  .tx_holding_empty_out(tx_holding_empty_out), .fifo_enable_out(fifo_enable_out),
  .overrun_out(overrun_out), .irq_out(irq_out));

/* File: sim/uart_shadow_far.sv */
// Remote serial station: sends 8N1 frames and decodes the block's output
`timescale 1ns/1ns
`include "uart_shadow_cfg.svh"
module uart_shadow_far (
  // Clock and mode
  input  wire logic       clk_in,
  input  wire logic       ir_in,
  // Lines from the block
  input  wire logic       tx_line_in,
  input  wire logic       tx_ir_low_in,
  // Lines to the block, idle high
  output logic            rx_line_out,
  output logic            rx_ir_out,
  // Decoded byte
  output logic      [7:0] byte_out,
  output logic            valid_out
);
  localparam int BITC = `UART_BIT_CYCLES;
  logic line;
  assign line = ir_in ? tx_ir_low_in : tx_line_in;
  initial begin
    rx_line_out = 1'b1;
    rx_ir_out = 1'b1;
    byte_out = 8'h00;
    valid_out = 1'b0;
  end
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_in);
      if (ir_in) rx_ir_out <= f[i];
      else rx_line_out <= f[i];
      repeat (BITC - 1) @(posedge clk_in);
    end
  endtask
  // Sample mid-bit; a bad stop bit gives no byte
  always begin
    @(negedge line);
    repeat (BITC / 2) @(posedge clk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (BITC) @(posedge clk_in);
      byte_out[i] <= line;
    end
    repeat (BITC) @(posedge clk_in);
    valid_out <= line;
    @(posedge clk_in);
    valid_out <= 1'b0;
  end
endmodule

/* File: sim/test_uart_shadow_rx_tx_buffer.sv */
// Self-checking bench for the shadow receive and transmit path
`timescale 1ns/1ns
`include "uart_shadow_cfg.svh"
module test_uart_shadow_rx_tx_buffer;
  logic        clk_in;
  logic        rst_in;
  logic [31:0] addr_in;
  logic [31:0] wr_data_in;
  logic        wr_en_in;
  logic        rd_en_in;
  logic [31:0] rd_data_out;
  logic        serial_in;
  logic        infrared_in;
  logic        serial_out;
  logic        infrared_out_low;
  logic        rx_data_ready_out;
  logic        tx_holding_empty_out;
  logic        fifo_enable_out;
  logic        overrun_out;
  logic        irq_out;
  logic        ir_mode;
  logic [7:0]  far_byte;
  logic        far_valid;
  logic        rd_pend;
  logic [7:0]  b[3];
  logic [7:0]  d[20];
  logic [31:0] rq[$];
  logic [7:0]  tq[$];
  int          miscompares;
  int          n_compared;
  int          cycles;
  uart_shadow_rx_tx_buffer uart_shadow_rx_tx_buffer_i (
    .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in),
    .rd_en_in(rd_en_in), .rd_data_out(rd_data_out), .serial_in(serial_in), .infrared_in(infrared_in),
    .serial_out(serial_out), .infrared_out_low(infrared_out_low), .rx_data_ready_out(rx_data_ready_out),
    .tx_holding_empty_out(tx_holding_empty_out), .fifo_enable_out(fifo_enable_out),
    .overrun_out(overrun_out), .irq_out(irq_out));
  uart_shadow_far uart_shadow_far_i (
    .clk_in(clk_in), .ir_in(ir_mode), .tx_line_in(serial_out), .tx_ir_low_in(infrared_out_low),
    .rx_line_out(serial_in), .rx_ir_out(infrared_in), .byte_out(far_byte), .valid_out(far_valid));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("compared %0d, wrong %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge clk_in);
      wr_en_in <= 1'b0;
      rd_en_in <= 1'b0;
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge clk_in);
    addr_in <= a;
    wr_data_in <= v;
    wr_en_in <= 1'b1;
    rd_en_in <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge clk_in);
    addr_in <= a;
    wr_en_in <= 1'b0;
    rd_en_in <= 1'b1;
    rq.push_back(e);
  endtask
  task automatic tx_far(input logic [7:0] v);
    cyc(1);
    uart_shadow_far_i.send(v);
  endtask
  task automatic wait_ready();
    for (int k = 0; k < 2000 && rx_data_ready_out !== 1'b1; k++) cyc(1);
  endtask
  // Bytes still due from the shifter bound the wait
  task automatic drain();
    for (int k = 0; k < 30000 && tq.size() > 0; k++) cyc(1);
  endtask
  function automatic logic [31:0] slot();
    return `UART_SLOT_BASE + 32'($urandom_range(15)) * 32'h4;
  endfunction
  always @(posedge clk_in) begin
    if (rd_pend) check(rd_data_out, rq.pop_front());
    if (far_valid === 1'b1) check({24'h0, far_byte}, {24'h0, tq.pop_front()});
    rd_pend <= rd_en_in;
    cycles++;
    if (cycles == 90000) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    void'($urandom(67279));
    rst_in = 1'b1;
    addr_in = 32'h0;
    wr_data_in = 32'h0;
    wr_en_in = 1'b0;
    rd_en_in = 1'b0;
    ir_mode = 1'b0;
    miscompares = 0;
    n_compared = 0;
    cyc(2);
    rst_in <= 1'b0;
    wr(32'h50001080, 32'hf);
    rd(`UART_LSTAT_ADDR, 32'h20);
    rd(`UART_IMASK_ADDR, 32'h0);
    rd(32'h50001080, 32'h0);
    rd(slot(), 32'h0);
    cyc(1);
    $display("test reset done");
    foreach (b[i]) b[i] = 8'($urandom);
    tq.push_back(b[0]);
    tq.push_back(b[2]);
    wr(`UART_IMASK_ADDR, 32'h4);
    wr(slot(), {24'h0, b[0]});
    cyc(3);
    wr(slot(), {24'h0, b[1]});
    wr(slot(), {24'h0, b[2]});
    rd(`UART_LSTAT_ADDR, 32'h0);
    drain();
    cyc(2);
    check({31'h0, irq_out}, 32'h1);
    check({31'h0, tx_holding_empty_out}, 32'h1);
    wr(`UART_IMASK_ADDR, 32'h0);
    cyc(2);
    check({31'h0, irq_out}, 32'h0);
    rd(`UART_ISTAT_ADDR, 32'h4);
    wr(`UART_ISTAT_ADDR, 32'h4);
    rd(`UART_ISTAT_ADDR, 32'h0);
    cyc(1);
    $display("test transmit done");
    foreach (b[i]) b[i] = 8'($urandom);
    wr(`UART_IMASK_ADDR, 32'h2);
    tx_far(b[0]);
    wait_ready();
    rd(slot(), {24'h0, b[0]});
    tx_far(b[1]);
    tx_far(b[2]);
    cyc(4);
    check({31'h0, overrun_out}, 32'h1);
    check({31'h0, irq_out}, 32'h1);
    check({31'h0, rx_data_ready_out}, 32'h1);
    rd(`UART_LSTAT_ADDR, 32'h23);
    rd(slot(), {24'h0, b[2]});
    rd(`UART_LSTAT_ADDR, 32'h20);
    rd(`UART_ISTAT_ADDR, 32'h3);
    wr(`UART_ISTAT_ADDR, 32'hf);
    cyc(2);
    check({31'h0, irq_out}, 32'h0);
    $display("test receive done");
    foreach (b[i]) b[i] = 8'($urandom);
    wr(`UART_CTRL_ADDR, 32'h2);
    ir_mode <= 1'b1;
    rd(`UART_CTRL_ADDR, 32'h2);
    tq.push_back(b[0]);
    wr(slot(), {24'h0, b[0]});
    cyc(3);
    check({31'h0, serial_out}, 32'h1);
    tx_far(b[1]);
    wait_ready();
    rd(slot(), {24'h0, b[1]});
    drain();
    $display("test infrared done");
    // Only the first frames finish; the rest stay queued at the end
    foreach (d[i]) d[i] = 8'($urandom);
    for (int i = 0; i < 17; i++) tq.push_back(d[i]);
    wr(`UART_CTRL_ADDR, 32'h1);
    ir_mode <= 1'b0;
    wr(slot(), {24'h0, d[0]});
    cyc(3);
    wr(`UART_ISTAT_ADDR, 32'hf);
    for (int i = 1; i < 20; i++) wr(slot(), {24'h0, d[i]});
    rd(`UART_ISTAT_ADDR, 32'h8);
    rd(`UART_LSTAT_ADDR, 32'h0);
    check({30'h0, fifo_enable_out, tx_holding_empty_out}, 32'h2);
    foreach (b[i]) b[i] = 8'($urandom);
    tx_far(b[0]);
    tx_far(b[1]);
    rd(slot(), {24'h0, b[0]});
    rd(slot(), {24'h0, b[1]});
    rd(`UART_LSTAT_ADDR, 32'h0);
    cyc(3);
    $display("test fifo done");
    test_done();
  end
endmodule
